// [src/ddclk_link_regs.sv]
// Functional notes
// RQ1: decimating modes always output signed two's complement samples.
// RQ2: host changes output mode only while link enable is zero.
// RQ3: host clears link enable before altering first link control fields.
// RQ4: link enable low holds link in reset, serializers down, clocks gated.
// RQ5: host writes second link control only with link enable zero.
// RQ6: host updates device identifier only with link enable zero.
// RQ7: host writes third link control only with link enable zero.
// RQ8: rewriting over-range period while enabled may shift monitoring phase.
// RQ9: decimating output is 15-bit in-phase plus 15-bit quadrature.
// RQ10: decimation one bypasses the converter, sending raw 12-bit samples.
// RQ11: decimation selectable from divide-by-4 up to divide-by-32.
// RQ12: startup: clear enable, program settings, calibrate, then set enable.
// RQ13: after calibration trigger, host toggles link enable to restart link.
// RQ14: reset loads every register with listed value; status undefined.
`timescale 1ns/1ps
`default_nettype none

module ddclk_link_regs
#(
  parameter int OVR_PERIOD_UNIT = 16
)
(
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // serial control pins
  input wire logic serialClock,
  input wire logic serialSelect_n,
  input wire logic serialDataIn,
  output logic serialDataOut,
  output logic serialDataOe,
  // link status inputs from the link core
  input wire logic [7:0] linkStatusIn,
  // over-range event from the converter
  input wire logic overRangeIn,
  // link control outputs
  output logic linkReset,
  output logic serializerPowerDown,
  output logic serializerClockEnable,
  // datapath configuration
  output logic downconverterBypass,
  output logic outputTwosComplement,
  output logic [4:0] sampleWidth,
  output logic [5:0] decimationFactor,
  output logic [2:0] converterOutputModeSelect,
  // over-range monitor
  output logic overRangeFlag
);

  initial
  begin
    if (OVR_PERIOD_UNIT < 1)
      $error("OVR_PERIOD_UNIT must be positive");
  end

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0] pinMeta_reg;
  logic [2:0] pinSync_reg;

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      // idle pin levels: clock low, select high, data low, so no false clock edge follows reset
      pinMeta_reg <= 3'h2;
      pinSync_reg <= 3'h2;
    end
    else
    begin
      pinMeta_reg <= {serialClock, serialSelect_n, serialDataIn};
      pinSync_reg <= pinMeta_reg;
    end
  end

  ddclk_reg_if regBus ();

  ddclk_serial_port u_port
  (
    .clock(clock),
    .reset(reset),
    .sclkSync(pinSync_reg[2]),
    .csSync(pinSync_reg[1]),
    .sdiSync(pinSync_reg[0]),
    .sdoOut(serialDataOut),
    .sdoOe(serialDataOe),
    .regs(regBus.port)
  );

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed
  {
    logic [7:0] ddcControl;
    logic [7:0] linkFirst;
    logic [7:0] linkSecond;
    logic [7:0] deviceIdent;
    logic [7:0] linkThird;
    logic [7:0] status;
    logic [7:0] thrLow;
    logic [7:0] thrHigh;
    logic [7:0] ovrPeriod;
    logic [7:0] presetMode;
    logic [7:0] presetSelect;
    logic [15:0] rationalDiv;
    logic [15:0] ovrCount;
    logic ovrSeen;
    logic ovrFlag;
    logic linkRst;
    logic serPd;
    logic serClkEn;
    logic bypass;
    logic twos;
    logic [4:0] width;
    logic [5:0] factor;
    logic [2:0] mode;
  } ddclk_state_t;

  ddclk_state_t r_reg;
  ddclk_state_t r_next;

  logic linkOn;
  logic [2:0] decimCode;
  assign linkOn = r_reg.linkFirst[ddclk_pkg::LINK_ENABLE_BIT];
  assign decimCode = r_reg.ddcControl[ddclk_pkg::DECIM_LSB +: ddclk_pkg::DECIM_W];

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always_comb
  begin
    case (regBus.addr)
      ddclk_pkg::ADDR_DDC_CONTROL: regBus.rdData = r_reg.ddcControl;
      ddclk_pkg::ADDR_LINK_CONTROL_FIRST: regBus.rdData = r_reg.linkFirst;
      ddclk_pkg::ADDR_LINK_CONTROL_SECOND: regBus.rdData = r_reg.linkSecond;
      ddclk_pkg::ADDR_LINK_DEVICE_IDENT: regBus.rdData = r_reg.deviceIdent;
      ddclk_pkg::ADDR_LINK_CONTROL_THIRD: regBus.rdData = r_reg.linkThird;
      ddclk_pkg::ADDR_LINK_SYSTEM_STATUS: regBus.rdData = r_reg.status;
      ddclk_pkg::ADDR_OVR_THRESHOLD_LOW: regBus.rdData = r_reg.thrLow;
      ddclk_pkg::ADDR_OVR_THRESHOLD_HIGH: regBus.rdData = r_reg.thrHigh;
      ddclk_pkg::ADDR_OVR_PERIOD: regBus.rdData = r_reg.ovrPeriod;
      ddclk_pkg::ADDR_OSC_PRESET_MODE: regBus.rdData = r_reg.presetMode;
      ddclk_pkg::ADDR_OSC_PRESET_SELECT: regBus.rdData = r_reg.presetSelect;
      ddclk_pkg::ADDR_RATIONAL_DIV_LOW: regBus.rdData = r_reg.rationalDiv[7:0];
      ddclk_pkg::ADDR_RATIONAL_DIV_HIGH: regBus.rdData = r_reg.rationalDiv[15:8];
      default: regBus.rdData = 8'h00;
    endcase
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    r_next = r_reg;
    r_next.status = linkStatusIn;
    if (regBus.wrStrobe)
    begin
      // the device does not police the enable-low rule; the host keeps it
      case (regBus.addr)
        ddclk_pkg::ADDR_DDC_CONTROL: r_next.ddcControl = regBus.wrData; // RQ2
        ddclk_pkg::ADDR_LINK_CONTROL_FIRST: r_next.linkFirst = regBus.wrData; // RQ3
        ddclk_pkg::ADDR_LINK_CONTROL_SECOND: r_next.linkSecond = regBus.wrData; // RQ5
        ddclk_pkg::ADDR_LINK_DEVICE_IDENT: r_next.deviceIdent = regBus.wrData; // RQ6
        ddclk_pkg::ADDR_LINK_CONTROL_THIRD: r_next.linkThird = regBus.wrData; // RQ7
        ddclk_pkg::ADDR_OVR_THRESHOLD_LOW: r_next.thrLow = regBus.wrData;
        ddclk_pkg::ADDR_OVR_THRESHOLD_HIGH: r_next.thrHigh = regBus.wrData;
        ddclk_pkg::ADDR_OVR_PERIOD:
        begin
          r_next.ovrPeriod = regBus.wrData;
          r_next.ovrCount = 16'h0000; // RQ8
        end
        ddclk_pkg::ADDR_OSC_PRESET_MODE: r_next.presetMode = regBus.wrData;
        ddclk_pkg::ADDR_OSC_PRESET_SELECT: r_next.presetSelect = regBus.wrData;
        ddclk_pkg::ADDR_RATIONAL_DIV_LOW: r_next.rationalDiv[7:0] = regBus.wrData;
        ddclk_pkg::ADDR_RATIONAL_DIV_HIGH: r_next.rationalDiv[15:8] = regBus.wrData;
        default: r_next.status = linkStatusIn;
      endcase
    end
    // link held in reset with serializers off and clocks gated while disabled
    r_next.linkRst = ~linkOn; // RQ4
    r_next.serPd = ~linkOn; // RQ4
    r_next.serClkEn = linkOn; // RQ4
    // datapath shape from the decimation code; output mode select from the mode field
    r_next.bypass = (decimCode == ddclk_pkg::DECIM_BYPASS); // RQ10
    r_next.twos = ~r_next.bypass; // RQ1
    r_next.width = r_next.bypass ? 5'(ddclk_pkg::SAMPLE_BITS) : 5'(ddclk_pkg::IQ_BITS); // RQ9 RQ10
    if (r_next.bypass)
      r_next.factor = 6'h01;
    else if (decimCode > ddclk_pkg::DECIM_MAX)
      r_next.factor = 6'h20; // RQ11
    else
      r_next.factor = 6'(6'h02 << decimCode); // RQ11
    r_next.mode = r_reg.ddcControl[ddclk_pkg::MODE_LSB +: ddclk_pkg::MODE_W];
    // over-range monitoring window, length set by period register
    if (overRangeIn)
      r_next.ovrSeen = 1'b1;
    if (r_reg.ovrCount >= 16'((r_reg.ovrPeriod + 9'h001) * OVR_PERIOD_UNIT - 1))
    begin
      r_next.ovrCount = 16'h0000;
      r_next.ovrFlag = r_reg.ovrSeen | overRangeIn;
      r_next.ovrSeen = 1'b0;
    end
    else if (!(regBus.wrStrobe && regBus.addr == ddclk_pkg::ADDR_OVR_PERIOD))
      r_next.ovrCount = r_reg.ovrCount + 16'h0001;
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      r_reg <= '0;
      r_reg.ddcControl <= ddclk_pkg::RST_DDC_CONTROL; // RQ14
      r_reg.linkFirst <= ddclk_pkg::RST_LINK_CONTROL_FIRST; // RQ14
      r_reg.thrLow <= ddclk_pkg::RST_OVR_THRESHOLD_LOW; // RQ14
      r_reg.thrHigh <= ddclk_pkg::RST_OVR_THRESHOLD_HIGH; // RQ14
      r_reg.serPd <= 1'b0;
      r_reg.serClkEn <= 1'b1;
      r_reg.bypass <= 1'b1;
      r_reg.width <= 5'(ddclk_pkg::SAMPLE_BITS);
      r_reg.factor <= 6'h01;
      r_reg.mode <= 3'h1;
    end
    else
      r_reg <= r_next;
  end

  assign linkReset = r_reg.linkRst;
  assign serializerPowerDown = r_reg.serPd;
  assign serializerClockEnable = r_reg.serClkEn;
  assign downconverterBypass = r_reg.bypass;
  assign outputTwosComplement = r_reg.twos;
  assign sampleWidth = r_reg.width;
  assign decimationFactor = r_reg.factor;
  assign converterOutputModeSelect = r_reg.mode;
  assign overRangeFlag = r_reg.ovrFlag;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_enableDrop;
    $fell(linkOn);
  endsequence

  a_link_held_off: assert property (@(posedge clock) disable iff (reset) // RQ4
    s_enableDrop |=> linkReset && serializerPowerDown && !serializerClockEnable)
    else $error("link not held off after enable cleared");

  a_link_released: assert property (@(posedge clock) disable iff (reset) // RQ4
    $rose(linkOn) |=> !linkReset && serializerClockEnable)
    else $error("link not released after enable set");

  a_decim_twos: assert property (@(posedge clock) disable iff (reset) // RQ1
    !downconverterBypass |-> outputTwosComplement)
    else $error("decimated output not twos complement");

  a_iq_width: assert property (@(posedge clock) disable iff (reset) // RQ9
    !downconverterBypass |-> sampleWidth == 5'(ddclk_pkg::IQ_BITS))
    else $error("decimated width wrong");

  a_bypass_raw: assert property (@(posedge clock) disable iff (reset) // RQ10
    (decimCode == ddclk_pkg::DECIM_BYPASS) |=> downconverterBypass && sampleWidth == 5'(ddclk_pkg::SAMPLE_BITS))
    else $error("bypass not raw twelve bit");

  a_decim_range: assert property (@(posedge clock) disable iff (reset) // RQ11
    !downconverterBypass |-> decimationFactor >= 6'h04 && decimationFactor <= 6'h20)
    else $error("decimation factor out of range");

  a_period_restart: assert property (@(posedge clock) disable iff (reset) // RQ8
    regBus.wrStrobe && regBus.addr == ddclk_pkg::ADDR_OVR_PERIOD |=> r_reg.ovrCount == 16'h0000)
    else $error("over-range window not restarted");

  a_write_lands: assert property (@(posedge clock) disable iff (reset) // RQ6
    regBus.wrStrobe && regBus.addr == ddclk_pkg::ADDR_LINK_DEVICE_IDENT |=> r_reg.deviceIdent == $past(regBus.wrData))
    else $error("identifier write lost");

  a_link_outputs_agree: assert property (@(posedge clock) disable iff (reset) // RQ4
    serializerPowerDown == linkReset && serializerClockEnable == !linkReset)
    else $error("link control outputs disagree");

  a_link_powered_up: assert property (@(posedge clock) disable iff (reset) // RQ4
    $rose(linkOn) |=> !serializerPowerDown)
    else $error("serializers still down after enable set");

  a_bypass_factor: assert property (@(posedge clock) disable iff (reset) // RQ10
    downconverterBypass |-> decimationFactor == 6'h01)
    else $error("bypass factor not one");

  a_first_write_lands: assert property (@(posedge clock) disable iff (reset) // RQ3
    regBus.wrStrobe && regBus.addr == ddclk_pkg::ADDR_LINK_CONTROL_FIRST |=> r_reg.linkFirst == $past(regBus.wrData))
    else $error("first link control write lost");

  a_period_write_lands: assert property (@(posedge clock) disable iff (reset) // RQ8
    regBus.wrStrobe && regBus.addr == ddclk_pkg::ADDR_OVR_PERIOD |=> r_reg.ovrPeriod == $past(regBus.wrData))
    else $error("over-range period write lost");

  a_status_follows: assert property (@(posedge clock) disable iff (reset) // RQ14
    1'b1 |=> r_reg.status == $past(linkStatusIn))
    else $error("status register not following link status");

  a_mode_follows: assert property (@(posedge clock) disable iff (reset) // RQ2
    1'b1 |=> converterOutputModeSelect == $past(r_reg.ddcControl[ddclk_pkg::MODE_LSB +: ddclk_pkg::MODE_W]))
    else $error("output mode select not following control register");

endmodule : ddclk_link_regs

`default_nettype wire

// [src/ddclk_pkg.sv]
package ddclk_pkg;

  // ----------------------------------------
  // register offsets (15-bit serial address)
  // ----------------------------------------
  localparam logic [14:0] ADDR_DDC_CONTROL = 15'h0200;
  localparam logic [14:0] ADDR_LINK_CONTROL_FIRST = 15'h0201;
  localparam logic [14:0] ADDR_LINK_CONTROL_SECOND = 15'h0202;
  localparam logic [14:0] ADDR_LINK_DEVICE_IDENT = 15'h0203;
  localparam logic [14:0] ADDR_LINK_CONTROL_THIRD = 15'h0204;
  localparam logic [14:0] ADDR_LINK_SYSTEM_STATUS = 15'h0205;
  localparam logic [14:0] ADDR_OVR_THRESHOLD_LOW = 15'h0206;
  localparam logic [14:0] ADDR_OVR_THRESHOLD_HIGH = 15'h0207;
  localparam logic [14:0] ADDR_OVR_PERIOD = 15'h0208;
  localparam logic [14:0] ADDR_OSC_PRESET_MODE = 15'h020C;
  localparam logic [14:0] ADDR_OSC_PRESET_SELECT = 15'h020D;
  localparam logic [14:0] ADDR_RATIONAL_DIV_LOW = 15'h020E;
  localparam logic [14:0] ADDR_RATIONAL_DIV_HIGH = 15'h020F;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] RST_DDC_CONTROL = 8'h10;
  localparam logic [7:0] RST_LINK_CONTROL_FIRST = 8'h0F;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_OVR_THRESHOLD_LOW = 8'hF2;
  localparam logic [7:0] RST_OVR_THRESHOLD_HIGH = 8'hAB;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int LINK_ENABLE_BIT = 0;
  localparam int DECIM_LSB = 0;
  localparam int DECIM_W = 3;
  localparam int MODE_LSB = 4;
  localparam int MODE_W = 3;

  // decimation codes: 0 = bypass (by 1), 1..4 = by 4, 8, 16, 32
  localparam logic [2:0] DECIM_BYPASS = 3'h0;
  localparam logic [2:0] DECIM_MAX = 3'h4;

  // ----------------------------------------
  // serial frame layout
  // ----------------------------------------
  localparam int FRAME_BITS = 24;
  localparam int ADDR_BITS = 15;
  localparam int DATA_BITS = 8;
  localparam int SAMPLE_BITS = 12;
  localparam int IQ_BITS = 15;

  typedef enum logic [1:0]
  {
    DDCLK_IDLE = 2'b00,
    DDCLK_ADDR = 2'b01,
    DDCLK_DATA = 2'b10
  } ddclk_spi_state_t;

endpackage : ddclk_pkg

// [src/ddclk_reg_if.sv]
`timescale 1ns/1ps
`default_nettype none

// one decoded register access from the serial port
interface ddclk_reg_if;
  logic wrStrobe;
  logic [14:0] addr;
  logic [7:0] wrData;
  logic [7:0] rdData;

  modport port
  (
    output wrStrobe,
    output addr,
    output wrData,
    input rdData
  );

  modport bank
  (
    input wrStrobe,
    input addr,
    input wrData,
    output rdData
  );
endinterface : ddclk_reg_if

`default_nettype wire

// [src/ddclk_serial_port.sv]
`timescale 1ns/1ps
`default_nettype none

module ddclk_serial_port
(
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // synchronised pins
  input wire logic sclkSync,
  input wire logic csSync,
  input wire logic sdiSync,
  // serial out
  output logic sdoOut,
  output logic sdoOe,
  // register side
  ddclk_reg_if.port regs
);

  typedef struct packed
  {
    ddclk_pkg::ddclk_spi_state_t state;
    logic sclkPrev;
    logic isRead;
    logic [4:0] bitCount;
    logic [14:0] addr;
    logic [7:0] shift;
    logic wr;
    logic sdo;
    logic oe;
  } ddclk_spi_t;

  ddclk_spi_t s_reg;
  ddclk_spi_t s_next;

  wire logic rise = sclkSync & ~s_reg.sclkPrev;
  wire logic fall = ~sclkSync & s_reg.sclkPrev;

  // ----------------------------------------
  // frame decode with streaming auto-increment
  // ----------------------------------------
  always_comb
  begin
    s_next = s_reg;
    s_next.sclkPrev = sclkSync;
    s_next.wr = 1'b0;
    if (csSync)
    begin
      s_next.state = ddclk_pkg::DDCLK_IDLE;
      s_next.oe = 1'b0;
      s_next.bitCount = 5'h00;
    end
    else if (rise)
    begin
      case (s_reg.state)
        ddclk_pkg::DDCLK_IDLE:
        begin
          s_next.isRead = sdiSync;
          s_next.state = ddclk_pkg::DDCLK_ADDR;
          s_next.bitCount = 5'h00;
        end
        ddclk_pkg::DDCLK_ADDR:
        begin
          s_next.addr = {s_reg.addr[13:0], sdiSync};
          s_next.bitCount = s_reg.bitCount + 5'h01;
          if (s_reg.bitCount == 5'(ddclk_pkg::ADDR_BITS - 1))
          begin
            s_next.state = ddclk_pkg::DDCLK_DATA;
            s_next.bitCount = 5'h00;
          end
        end
        ddclk_pkg::DDCLK_DATA:
        begin
          s_next.shift = {s_reg.shift[6:0], sdiSync};
          s_next.bitCount = s_reg.bitCount + 5'h01;
          if (s_reg.bitCount == 5'(ddclk_pkg::DATA_BITS - 1))
          begin
            s_next.wr = ~s_reg.isRead;
            s_next.bitCount = 5'h00;
            // a streamed read needs the next register on the bus before its first falling edge
            if (s_reg.isRead)
              s_next.addr = s_reg.addr + 15'h0001;
          end
        end
        default:
          s_next.state = ddclk_pkg::DDCLK_IDLE;
      endcase
    end
    else if (fall && s_reg.state == ddclk_pkg::DDCLK_DATA && s_reg.isRead)
    begin
      // read data leaves msb first on the falling edge
      s_next.oe = 1'b1;
      s_next.sdo = regs.rdData[3'(ddclk_pkg::DATA_BITS - 1) - s_reg.bitCount[2:0]];
    end
    // advance write address after the strobe for streaming
    if (s_reg.wr)
      s_next.addr = s_reg.addr + 15'h0001;
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      s_reg <= '{state: ddclk_pkg::DDCLK_IDLE, default: '0};
    else
      s_reg <= s_next;
  end

  assign regs.wrStrobe = s_reg.wr;
  assign regs.addr = s_reg.addr;
  assign regs.wrData = s_reg.shift;
  assign sdoOut = s_reg.sdo;
  assign sdoOe = s_reg.oe;

endmodule : ddclk_serial_port

`default_nettype wire

// [tb/ddclk_host_model.sv]
`timescale 1ns/1ps
`default_nettype none

module ddclk_host_model
#(
  parameter int HALF = 6
)
(
  // system clock, used only to pace the serial pins
  input wire logic clock,
  // serial control pins
  output logic serialClock,
  output logic serialSelect_n,
  output logic serialDataIn,
  input wire logic serialDataOut,
  input wire logic serialDataOe
);
  logic wireLevel;

  initial
  begin
    serialClock = 1'b0;
    serialSelect_n = 1'b1;
    serialDataIn = 1'b0;
  end

  // a released data line shows the inverse of its last value, so a stale bit never reads as data
  assign wireLevel = serialDataOe ? serialDataOut : ~serialDataOut;

  // ----------------------------------------
  // bit level
  // ----------------------------------------
  // half periods of 6 clocks leave room for the 2-stage pin synchronisers
  task automatic shift_bit(input logic b, output logic seen);
    serialClock = 1'b0;
    serialDataIn = b;
    repeat (HALF) @(negedge clock);
    seen = wireLevel;
    serialClock = 1'b1;
    repeat (HALF) @(negedge clock);
  endtask : shift_bit

  // ----------------------------------------
  // frame level
  // ----------------------------------------
  task automatic start_frame(input logic rw, input logic [14:0] addr);
    logic seen;
    @(negedge clock);
    serialSelect_n = 1'b0;
    shift_bit(rw, seen);
    for (int i = 14; i >= 0; i--) shift_bit(addr[i], seen);
  endtask : start_frame

  task automatic move_byte(input logic [7:0] wr, output logic [7:0] rd);
    for (int i = 7; i >= 0; i--) shift_bit(wr[i], rd[i]);
  endtask : move_byte

  // the serial clock stands still low between frames
  task automatic end_frame();
    serialClock = 1'b0;
    repeat (HALF) @(negedge clock);
    serialSelect_n = 1'b1;
    repeat (2 * HALF) @(negedge clock);
  endtask : end_frame
endmodule : ddclk_host_model

`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ps
`default_nettype none

module testbench;
  localparam int UNIT = 4;
  logic clock, reset, overRangeIn;
  logic [7:0] linkStatusIn;
  wire logic serialClock, serialSelect_n, serialDataIn, serialDataOut, serialDataOe;
  wire logic linkReset, serializerPowerDown, serializerClockEnable;
  wire logic downconverterBypass, outputTwosComplement, overRangeFlag;
  wire logic [4:0] sampleWidth;
  wire logic [5:0] decimationFactor;
  wire logic [2:0] converterOutputModeSelect;
  int n_errors = 0;
  int total_checks = 0;

  ddclk_link_regs #(.OVR_PERIOD_UNIT(UNIT)) dut_u
  (
    .clock(clock), .reset(reset), .serialClock(serialClock), .serialSelect_n(serialSelect_n),
    .serialDataIn(serialDataIn), .serialDataOut(serialDataOut), .serialDataOe(serialDataOe),
    .linkStatusIn(linkStatusIn), .overRangeIn(overRangeIn), .linkReset(linkReset),
    .serializerPowerDown(serializerPowerDown), .serializerClockEnable(serializerClockEnable),
    .downconverterBypass(downconverterBypass), .outputTwosComplement(outputTwosComplement),
    .sampleWidth(sampleWidth), .decimationFactor(decimationFactor),
    .converterOutputModeSelect(converterOutputModeSelect), .overRangeFlag(overRangeFlag)
  );

  ddclk_host_model host_u
  (
    .clock(clock), .serialClock(serialClock), .serialSelect_n(serialSelect_n),
    .serialDataIn(serialDataIn), .serialDataOut(serialDataOut), .serialDataOe(serialDataOe)
  );

  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // ----------------------------------------
  // compare and report
  // ----------------------------------------
  task automatic check_reg(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_reg

  task automatic check_pin(input logic [7:0] got, input logic [7:0] exp);
    check_reg(got, exp);
  endtask : check_pin

  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  // ----------------------------------------
  // register access
  // ----------------------------------------
  task automatic burst_wr(input logic [14:0] addr, input logic [7:0] data[$]);
    logic [7:0] rd;
    host_u.start_frame(1'b0, addr);
    foreach (data[i]) host_u.move_byte(data[i], rd);
    host_u.end_frame();
  endtask : burst_wr

  task automatic burst_chk(input logic [14:0] addr, input logic [7:0] exp[$]);
    logic [7:0] rd;
    host_u.start_frame(1'b1, addr);
    foreach (exp[i])
    begin
      host_u.move_byte(8'h00, rd);
      check_reg(rd, exp[i]);
    end
    check_pin({7'h00, serialDataOe}, 8'h01);
    host_u.end_frame();
    check_pin({7'h00, serialDataOe}, 8'h00);
  endtask : burst_chk

  task automatic check_link(input logic held);
    check_pin({7'h00, linkReset}, {7'h00, held});
    check_pin({7'h00, serializerPowerDown}, {7'h00, held});
    check_pin({7'h00, serializerClockEnable}, {7'h00, ~held});
  endtask : check_link

  task automatic check_path(input logic [2:0] code, input logic [2:0] mode);
    logic byp;
    byp = (code == 3'h0);
    check_pin({7'h00, downconverterBypass}, {7'h00, byp});
    check_pin({7'h00, outputTwosComplement}, {7'h00, ~byp});
    check_pin({3'h0, sampleWidth}, byp ? 8'h0C : 8'h0F);
    check_pin({2'h0, decimationFactor}, byp ? 8'h01 : 8'h01 << ((code > 3'h4 ? 3'h4 : code) + 3'h1));
    check_pin({5'h00, converterOutputModeSelect}, {5'h00, mode});
  endtask : check_path

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic reset_test();
    check_link(1'b0);
    check_path(3'h0, 3'h1);
    // streaming read of the whole bank; 0x205 mirrors status, 0x209..0x20B are unmapped
    burst_chk(ddclk_pkg::ADDR_DDC_CONTROL, '{8'h10, 8'h0F, 8'h00, 8'h00, 8'h00, 8'h5A, 8'hF2, 8'hAB,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    $display("test reset_test finished");
  endtask : reset_test

  task automatic overrange_test();
    int k;
    burst_wr(ddclk_pkg::ADDR_OVR_PERIOD, '{8'h01});
    burst_chk(ddclk_pkg::ADDR_OVR_PERIOD, '{8'h01});
    repeat (6 * UNIT) @(negedge clock);
    check_pin({7'h00, overRangeFlag}, 8'h00);
    overRangeIn = 1'b1;
    @(negedge clock);
    overRangeIn = 1'b0;
    k = 0;
    while (overRangeFlag !== 1'b1 && k < 6 * UNIT)
    begin
      @(negedge clock);
      k++;
    end
    check_pin({7'h00, overRangeFlag}, 8'h01);
    repeat (8 * UNIT) @(negedge clock);
    check_pin({7'h00, overRangeFlag}, 8'h00);
    $display("test overrange_test finished");
  endtask : overrange_test

  task automatic link_test();
    burst_wr(ddclk_pkg::ADDR_LINK_CONTROL_FIRST, '{8'h0E});
    check_link(1'b1);
    burst_wr(ddclk_pkg::ADDR_LINK_CONTROL_SECOND, '{8'h3C, 8'hA5, 8'h69, 8'hFF});
    burst_wr(ddclk_pkg::ADDR_RATIONAL_DIV_LOW, '{8'h34, 8'h12});
    burst_wr(15'h0209, '{8'h77});
    linkStatusIn = 8'hC3;
    burst_chk(ddclk_pkg::ADDR_LINK_CONTROL_FIRST, '{8'h0E, 8'h3C, 8'hA5, 8'h69, 8'hC3});
    burst_chk(15'h0209, '{8'h00});
    burst_chk(ddclk_pkg::ADDR_RATIONAL_DIV_LOW, '{8'h34, 8'h12});
    check_link(1'b1);
    $display("test link_test finished");
  endtask : link_test

  task automatic decim_test();
    for (int c = 0; c < 8; c++)
    begin
      burst_wr(ddclk_pkg::ADDR_DDC_CONTROL, '{{1'b0, 3'h5, 1'b0, 3'(c)}});
      check_path(3'(c), 3'h5);
    end
    $display("test decim_test finished");
  endtask : decim_test

  task automatic startup_test();
    burst_wr(ddclk_pkg::ADDR_DDC_CONTROL, '{8'h02});
    burst_wr(ddclk_pkg::ADDR_LINK_CONTROL_FIRST, '{8'h0F});
    check_link(1'b0);
    check_path(3'h2, 3'h0);
    burst_wr(ddclk_pkg::ADDR_LINK_CONTROL_FIRST, '{8'h0E});
    check_link(1'b1);
    burst_wr(ddclk_pkg::ADDR_LINK_CONTROL_FIRST, '{8'h0F});
    check_link(1'b0);
    $display("test startup_test finished");
  endtask : startup_test

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    reset = 1'b1;
    overRangeIn = 1'b0;
    linkStatusIn = 8'h5A;
    repeat (2) @(negedge clock);
    reset = 1'b0;
    repeat (2) @(negedge clock);
    reset_test();
    overrange_test();
    link_test();
    decim_test();
    startup_test();
    end_sim();
  end

  // a hang counts as a mismatch
  initial
  begin
    repeat (100000) @(posedge clock);
    n_errors++;
    end_sim();
  end
endmodule : testbench

`default_nettype wire
